// file: design/iow_consts.vh
// Offsets, field positions and reset values of the I/O window and downstream status block
`ifndef IOW_CONSTS_VH
`define IOW_CONSTS_VH
`define IOW_OFF_BOTTOM 8'h1c
`define IOW_OFF_TOP 8'h1d
`define IOW_OFF_STATUS 8'h1e
`define IOW_OFF_BOTTOM_UP 8'h30
`define IOW_OFF_TOP_UP 8'h32
`define IOW_OFF_BRIDGE_CTRL 8'h3e
`define IOW_WIN_MSB 7
`define IOW_WIN_LSB 4
`define IOW_CAP_VAL 4'h1
`define IOW_WIN_RESET 4'h0
`define IOW_UP_RESET 16'h0000
`define IOW_BOTTOM_LOW 12'h000
`define IOW_TOP_LOW 12'hfff
`define IOW_ST_PAR_FLAG 15
`define IOW_ST_SPEED_VAL 2'b01
`define IOW_ST_BIT7_VAL 1'b1
`define IOW_PAR_RESP_EN_BIT 0
`endif

// file: design/iow_window_status.v
// I/O window registers, window decode and downstream bus status register
//
// Contract
// [RULE_01] Bottom register bits 7:4 are writable I/O address bits 15:12 of window bottom.
// [RULE_02] Window bottom address bits 11:0 are taken as zero.
// [RULE_03] Top register bits 7:4 give address bits 15:12; bits 11:0 taken as ones.
// [RULE_04] Bottom address bits 31:16 come from upper-bottom register at offset 30h.
// [RULE_05] Top address bits 31:16 come from upper-top register at offset 32h.
// [RULE_06] Bits 3:0 of bottom and top read 1h and ignore writes.
// [RULE_07] Forward upstream I/O downstream only when address lies inside the window.
// [RULE_08] Status resets with bits 9 and 7 set, bit 5 strap, others clear; bit 5 here resets to 0 and takes the strap one clock after reset.
// [RULE_09] Set parity error flag on address or attribute error as potential target.
// [RULE_10] Set parity error flag on data error as target of a write.
// [RULE_11] Set parity error flag on immediate read data error as master.
// [RULE_12] Parity error flag sets regardless of parity response enable.
// [RULE_13] Status bits 10:9 read 01b, medium decode timing.
// [RULE_14] Parity error flag stays set until software clears it.
// [RULE_15] Window compare uses full 32-bit ends, both ends included.
`timescale 1ns/1ps
`default_nettype none
`include "iow_consts.vh"
module iow_window_status #(
    parameter BIT5_STATE = 1'b0
) (
    input wire i_clk_sys,
    input wire i_resetn,
    input wire [7:0] i_cfg_addr,
    input wire i_cfg_wr,
    input wire [15:0] i_cfg_wdata,
    input wire [1:0] i_cfg_be,
    output reg [15:0] o_cfg_rdata,
    input wire [15:0] i_io_window_bottom_upper,
    input wire [15:0] i_io_window_top_upper,
    input wire i_parity_response_enable,
    input wire i_addr_attr_err,
    input wire i_tgt_write_data_err,
    input wire i_mst_read_data_err,
    input wire i_io_req_valid,
    input wire [31:0] i_io_req_addr,
    output wire o_io_forward,
    output wire [31:0] o_window_bottom,
    output wire [31:0] o_window_top
);
    // ****************************************************************
    // Helper functions
    // ****************************************************************
    // Offset match, shared by the write strobes
    function addr_is;
        input [7:0] addr;
        input [7:0] offset;
        begin
            addr_is = (addr == offset);
        end
    endfunction

    // Writable window field of one byte lane
    function [3:0] win_field;
        input [7:0] lane;
        begin
            win_field = lane[`IOW_WIN_MSB:`IOW_WIN_LSB];
        end
    endfunction

    // Register byte as read back: window field over the fixed capability code
    function [7:0] win_byte;
        input [3:0] field;
        input [3:0] cap;
        begin
            win_byte = {field, cap};
        end
    endfunction

    // ****************************************************************
    // Register storage
    // ****************************************************************
    reg [3:0] io_window_bottom_bits;
    reg [3:0] io_window_top_bits;
    reg detected_parity_error_flag;
    reg bit5_strap;
    reg strap_taken;
    reg [3:0] next_io_window_bottom_bits;
    reg [3:0] next_io_window_top_bits;
    reg next_detected_parity_error_flag;
    reg next_bit5_strap;
    reg next_strap_taken;
    reg [15:0] next_cfg_rdata;
    wire [3:0] io_addressing_capability;
    wire hit_bottom;
    wire hit_top;
    wire hit_status;
    wire wr_bottom;
    wire wr_top_low_lane;
    wire wr_top_high_lane;
    wire clr_status;
    wire parity_event;
    wire [7:0] bottom_byte;
    wire [7:0] top_byte;
    wire [15:0] status_value;
    wire above_bottom;
    wire below_top;

    assign io_addressing_capability = `IOW_CAP_VAL; // [RULE_06]

    // ****************************************************************
    // Access decode
    // ****************************************************************
    assign hit_bottom = addr_is(i_cfg_addr, `IOW_OFF_BOTTOM);
    assign hit_top = addr_is(i_cfg_addr, `IOW_OFF_TOP);
    assign hit_status = addr_is(i_cfg_addr, `IOW_OFF_STATUS);
    assign wr_bottom = i_cfg_wr && hit_bottom && i_cfg_be[0];
    // A word write at the bottom offset carries the top register in its high lane
    assign wr_top_low_lane = i_cfg_wr && hit_top && i_cfg_be[0];
    assign wr_top_high_lane = i_cfg_wr && hit_bottom && i_cfg_be[1];
    // Writing zero leaves the flag alone; only a one in its bit clears it
    assign clr_status = i_cfg_wr && hit_status && i_cfg_be[1]
        && i_cfg_wdata[`IOW_ST_PAR_FLAG];

    // ****************************************************************
    // Downstream bus error events
    // ****************************************************************
    // Response enable left out on purpose: errors are recorded even when ignored
    assign parity_event = i_addr_attr_err // [RULE_09]
        || i_tgt_write_data_err // [RULE_10]
        || i_mst_read_data_err; // [RULE_11] [RULE_12]

    // ****************************************************************
    // Next state
    // ****************************************************************
    always @* begin
        next_io_window_bottom_bits = io_window_bottom_bits;
        if (wr_bottom) begin
            next_io_window_bottom_bits = win_field(i_cfg_wdata[7:0]); // [RULE_01]
        end
    end

    always @* begin
        next_io_window_top_bits = io_window_top_bits;
        if (wr_top_low_lane) begin
            next_io_window_top_bits = win_field(i_cfg_wdata[7:0]); // [RULE_03]
        end else if (wr_top_high_lane) begin
            next_io_window_top_bits = win_field(i_cfg_wdata[15:8]); // [RULE_03]
        end
    end

    // Set wins over a same-cycle clear so that no error event is lost
    always @* begin
        next_detected_parity_error_flag = detected_parity_error_flag; // [RULE_14]
        if (parity_event) begin
            next_detected_parity_error_flag = 1'b1;
        end else if (clr_status) begin
            next_detected_parity_error_flag = 1'b0; // [RULE_14]
        end
    end

    // Bit 5 is captured once after reset and never moves under software
    always @* begin
        next_bit5_strap = bit5_strap;
        next_strap_taken = 1'b1;
        if (!strap_taken) begin
            next_bit5_strap = BIT5_STATE[0]; // [RULE_08]
        end
    end

    // ****************************************************************
    // State registers
    // ****************************************************************
    always @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            io_window_bottom_bits <= `IOW_WIN_RESET;
            io_window_top_bits <= `IOW_WIN_RESET;
            detected_parity_error_flag <= 1'b0; // [RULE_08]
            bit5_strap <= 1'b0;
            strap_taken <= 1'b0;
        end else begin
            io_window_bottom_bits <= next_io_window_bottom_bits;
            io_window_top_bits <= next_io_window_top_bits;
            detected_parity_error_flag <= next_detected_parity_error_flag;
            bit5_strap <= next_bit5_strap;
            strap_taken <= next_strap_taken;
        end
    end

    // ****************************************************************
    // Window decode
    // ****************************************************************
    assign o_window_bottom = {
        i_io_window_bottom_upper, // [RULE_04]
        io_window_bottom_bits, // [RULE_01]
        `IOW_BOTTOM_LOW // [RULE_02]
    };
    assign o_window_top = {
        i_io_window_top_upper, // [RULE_05]
        io_window_top_bits, // [RULE_03]
        `IOW_TOP_LOW // [RULE_03]
    };
    // Both ends count as inside, so bottom equal to top still forwards one page
    assign above_bottom = (i_io_req_addr >= o_window_bottom); // [RULE_15]
    assign below_top = (i_io_req_addr <= o_window_top); // [RULE_15]
    // A top below the bottom gives an empty window and nothing is forwarded
    assign o_io_forward = i_io_req_valid && above_bottom && below_top; // [RULE_07]

    // ****************************************************************
    // Read path
    // ****************************************************************
    assign bottom_byte = win_byte(io_window_bottom_bits, io_addressing_capability); // [RULE_06]
    assign top_byte = win_byte(io_window_top_bits, io_addressing_capability); // [RULE_06]
    assign status_value = {
        detected_parity_error_flag, // [RULE_09]
        4'h0,
        `IOW_ST_SPEED_VAL, // [RULE_13]
        1'b0,
        `IOW_ST_BIT7_VAL, // [RULE_08]
        1'b0,
        bit5_strap, // [RULE_08]
        5'h00
    };

    always @* begin
        case (i_cfg_addr)
            `IOW_OFF_BOTTOM: begin
                next_cfg_rdata = {top_byte, bottom_byte};
            end
            `IOW_OFF_TOP: begin
                // The high lane is not mirrored from the status register
                next_cfg_rdata = {8'h00, top_byte};
            end
            `IOW_OFF_STATUS: begin
                next_cfg_rdata = status_value;
            end
            default: begin
                next_cfg_rdata = 16'h0000;
            end
        endcase
    end

    // One cycle of read latency keeps the data output on a flop
    always @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_cfg_rdata <= 16'h0000;
        end else begin
            o_cfg_rdata <= next_cfg_rdata;
        end
    end
endmodule
`default_nettype wire

// file: testbench/iow_checker.sv
// Checker for the I/O window and status block
`timescale 1ns/1ps
`default_nettype none
module iow_checker (input wire logic i_clk_sys, i_resetn, i_addr_attr_err, i_io_req_valid,
    o_io_forward, input wire logic [7:0] i_cfg_addr, input wire logic [15:0] o_cfg_rdata,
    input wire logic [31:0] i_io_req_addr, o_window_bottom, o_window_top);
default clocking @(posedge i_clk_sys); endclocking
default disable iff (!i_resetn);
AST_BLO: assert property (o_window_bottom[11:0] == 12'h000) else $error("low");
AST_TLO: assert property (o_window_top[11:0] == 12'hfff) else $error("top");
AST_FWD: assert property (o_io_forward == (i_io_req_valid
    && i_io_req_addr >= o_window_bottom && i_io_req_addr <= o_window_top)) else $error("fwd");
AST_CAP: assert property (i_cfg_addr == 8'h1c
    |=> o_cfg_rdata[11:8] == 4'h1 && o_cfg_rdata[3:0] == 4'h1) else $error("cap");
AST_WIN: assert property (i_cfg_addr == 8'h1c |=>
    {o_cfg_rdata[7:4], 12'h000} == ($past(o_window_bottom) & 32'h0000f000)) else $error("win");
AST_SPD: assert property (i_cfg_addr == 8'h1e |=> o_cfg_rdata[10:7] == 4'b0101)
    else $error("speed");
AST_RSV: assert property (i_cfg_addr == 8'h1e |=> (o_cfg_rdata & 16'h785f) == 16'h0000)
    else $error("rsv");
AST_PAR: assert property (i_addr_attr_err ##1 i_cfg_addr == 8'h1e |=> o_cfg_rdata[15])
    else $error("flag");
endmodule
bind iow_window_status iow_checker iow_checker_inst (.*);
`default_nettype wire

// file: testbench/iow_sec_agent.sv
// Secondary bus agent that reports one parity fault
`timescale 1ns/1ps
`default_nettype none
module iow_sec_agent (input wire logic i_clk, i_go, input wire logic [1:0] i_kind,
    output logic [2:0] o_err);
always @(posedge i_clk) o_err <= i_go ? 3'b001 << i_kind : 3'b000;
endmodule
`default_nettype wire

// file: testbench/iow_window_status_tb.sv
// Bench for the I/O window and status block
`timescale 1ns/1ps
`default_nettype none
module iow_window_status_tb;
logic i_clk_sys = 0, i_resetn = 0, i_cfg_wr = 0, i_parity_response_enable = 0, go = 0;
logic i_io_req_valid = 0, o_io_forward;
logic [1:0] i_cfg_be = 0, k = 0;
logic [7:0] i_cfg_addr = 0;
logic [15:0] i_cfg_wdata = 0, i_io_window_bottom_upper = 0, i_io_window_top_upper = 0, o_cfg_rdata;
logic [31:0] i_io_req_addr = 0, o_window_bottom, o_window_top, s = 32'hc1ada1bd, r, lo, hi, x;
wire i_addr_attr_err, i_tgt_write_data_err, i_mst_read_data_err;
int miscompares = 0, check_count = 0;
always #5 i_clk_sys = ~i_clk_sys;
iow_sec_agent iow_sec_agent_inst (.i_clk(i_clk_sys), .i_go(go), .i_kind(k),
    .o_err({i_mst_read_data_err, i_tgt_write_data_err, i_addr_attr_err}));
iow_window_status iow_window_status_inst (.*);
function logic [31:0] xs();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
endfunction
task chk(input logic [31:0] v, e);
    check_count++;
    if (v !== e) $display("Error %0t seen %h exp %h", $time, v, e);
    if (v !== e) miscompares++;
endtask
task give_verdict;
    if (miscompares == 0 && check_count > 0)
        $display("ALL TESTS PASSED");
    else
        $display("TESTS FAILED");
    $finish;
endtask
// Write then read back two edges later, sampled away from the clock edge
task acc(input logic [7:0] ad, input logic [1:0] b, input logic [15:0] d);
    @(posedge i_clk_sys) {i_cfg_addr, i_cfg_wr, i_cfg_be, i_cfg_wdata} <= {ad, 1'b1, b, d};
    @(posedge i_clk_sys) i_cfg_wr <= 0;
    @(posedge i_clk_sys) @(negedge i_clk_sys);
endtask
initial begin
    repeat (5) @(posedge i_clk_sys);
    i_resetn <= 1;
    // Reset values, with writes that hit no writable bit
    acc(8'h1c, 2'h0, 16'hffff);
    chk(o_cfg_rdata, 32'h0101);
    acc(8'h1e, 2'h1, 16'hffff);
    chk(o_cfg_rdata, 32'h0280);
    repeat (20) begin
        r = xs();
        acc(8'h1c, 2'h3, r[15:0]);
        chk(o_cfg_rdata, {r[15:12], 4'h1, r[7:4], 4'h1});
        lo = {15'h0, r[16], r[7:4], 12'h000};
        hi = {15'h0, r[17], r[15:12], 12'hfff};
        x = r[18] ? hi + 32'(r[19]) : lo - 32'(r[19]);
        @(posedge i_clk_sys) {i_io_req_valid, i_io_req_addr} <= {r[20], x};
        {i_io_window_bottom_upper, i_io_window_top_upper} <= {lo[31:16], hi[31:16]};
        @(negedge i_clk_sys) chk(o_io_forward, r[20] && x >= lo && x <= hi);
        chk(o_window_top, hi);
        chk(o_window_bottom, lo);
    end
    // Flag must survive a write without the clear bit, then clear on request
    for (int j = 0; j < 3; j++) begin
        @(posedge i_clk_sys) {go, k, i_parity_response_enable} <= {1'b1, j[1:0], j[0]};
        @(posedge i_clk_sys) go <= 0;
        acc(8'h1e, 2'h3, 16'h7fff);
        chk(o_cfg_rdata, 16'h8280);
        acc(8'h1e, 2'h2, 16'h8000);
        chk(o_cfg_rdata, 16'h0280);
    end
    give_verdict;
end
initial begin
    #20000 miscompares++;
    give_verdict;
end
endmodule
`default_nettype wire
